// file: include/core_sfr_pkg.sv
// Constants and types for the core register bank: port 0, stack, data pointer, power control
//
// Behaviour
// - Port 0 pins are open-drain when the pull-up select is 0, pulled up when 1.
// - With pull-ups selected port 0 behaves as a quasi-bidirectional port 2 pin.
// - External memory accesses put multiplexed address/data on port 0 instead of the latch.
// - Stack top pointer holds the scratch-pad address of the stack top.
// - Data pointer is 16 bits: low byte register below, high byte register above.
// - Power control bit 7 doubles the serial baud rate in serial modes 1, 2, 3.
// - Power control bit 6 turns serial control bit 7 from mode select into framing error.
// - Power-on reset sets power control bit 4; it stays set until software clears it.
// - Power control bits 3 and 2 are plain user storage flags.
// - Writing 1 to power control bit 1 enters power-down: all clocks stop.
// - Writing 1 to power control bit 0 with bit 1 at 0 enters idle: CPU clock stops, peripherals run.
// - Unimplemented bits and unmapped addresses read as 1.
package core_sfr_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [7:0] addr_t;

   // ****************************************************
   // Register addresses
   // ****************************************************
   localparam addr_t ADDR_PORT0_LATCH  = 8'h80;
   localparam addr_t ADDR_STACK_TOP    = 8'h81;
   localparam addr_t ADDR_DPTR_LOW     = 8'h82;
   localparam addr_t ADDR_DPTR_HIGH    = 8'h83;
   localparam addr_t ADDR_PULLUP_OPT   = 8'h86;
   localparam addr_t ADDR_POWER_CTRL   = 8'h87;
   localparam addr_t ADDR_EVENT_STATUS = 8'hf9;
   localparam addr_t ADDR_EVENT_MASK   = 8'hfa;

   // ****************************************************
   // Reset values
   // ****************************************************
   localparam byte_t RST_PORT0_LATCH  = 8'hff;
   localparam byte_t RST_STACK_TOP    = 8'h07;
   localparam byte_t RST_DPTR_LOW     = 8'h00;
   localparam byte_t RST_DPTR_HIGH    = 8'h00;
   localparam logic  RST_PULLUP_SEL   = 1'b1;
   localparam byte_t RST_POWER_CTRL   = 8'h30;
   localparam byte_t UNMAPPED_READ    = 8'hff;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int unsigned PULLUP_SEL_BIT   = 0;
   localparam int unsigned PC_BAUD_DOUBLE   = 7;
   localparam int unsigned PC_FRAME_ERR_SEL = 6;
   localparam int unsigned PC_RESERVED      = 5;
   localparam int unsigned PC_POR_FLAG      = 4;
   localparam int unsigned PC_USER_FLAG_B   = 3;
   localparam int unsigned PC_USER_FLAG_A   = 2;
   localparam int unsigned PC_POWER_DOWN    = 1;
   localparam int unsigned PC_CPU_HALT      = 0;

   // Sticky event bits
   localparam int unsigned EV_W          = 4;
   localparam int unsigned EV_IDLE_ENTRY = 0;
   localparam int unsigned EV_DOWN_ENTRY = 1;
   localparam int unsigned EV_WAKE       = 2;
   localparam int unsigned EV_POR_SEEN   = 3;
   localparam logic [EV_W-1:0] RST_EVENT_MASK = 4'h0;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_IDLE,
      PWR_DOWN
   } power_state_e;

endpackage

// file: include/sfr_write_if.sv
// Register write channel from the bus decode to the register-owning units
`timescale 1ns/1ps
interface sfr_write_if;
   import core_sfr_pkg::*;
   logic  we;
   addr_t addr;
   byte_t wdata;
   modport ctrl (output we, output addr, output wdata);
   modport unit (input we, input addr, input wdata);
endinterface

// file: verilog/port0_pad_ctrl.sv
// Port 0 latch, pull-up option and pin drive
`timescale 1ns/1ps
module port0_pad_ctrl
   import core_sfr_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   sfr_write_if.unit          wr,
   input  wire core_sfr_pkg::byte_t pinIn,
   input  wire logic          extBusActive,
   input  wire logic          extBusDrive,
   input  wire core_sfr_pkg::byte_t extBusAddrData,
   output core_sfr_pkg::byte_t latch_q,
   output logic               pullupSel_q,
   output core_sfr_pkg::byte_t pinSync_q,
   output core_sfr_pkg::byte_t pinOut_q,
   output core_sfr_pkg::byte_t pinOeN_q,
   output core_sfr_pkg::byte_t pullupEn_q
);
   byte_t pinMeta_q;
   byte_t latchPrev_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         latch_q     <= RST_PORT0_LATCH;
         latchPrev_q <= RST_PORT0_LATCH;
      end else begin
         if (wr.we && wr.addr == ADDR_PORT0_LATCH) begin
            latch_q <= wr.wdata;
         end
         latchPrev_q <= latch_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pullupSel_q <= RST_PULLUP_SEL;
      end else if (wr.we && wr.addr == ADDR_PULLUP_OPT) begin
         pullupSel_q <= wr.wdata[PULLUP_SEL_BIT];
      end
   end

   // Pins come from outside: two flops before anyone looks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_q <= 8'hff;
         pinSync_q <= 8'hff;
      end else begin
         pinMeta_q <= pinIn;
         pinSync_q <= pinMeta_q;
      end
   end

   generate
      for (genvar i = 0; i < 8; i++) begin : g_pin
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               pinOut_q[i]   <= 1'b1;
               pinOeN_q[i]   <= 1'b1;
               pullupEn_q[i] <= 1'b0;
            end else if (extBusActive) begin
               // Bus cycle: push both levels when driving, float for reads
               pinOut_q[i]   <= extBusAddrData[i];
               pinOeN_q[i]   <= ~extBusDrive;
               pullupEn_q[i] <= 1'b0;
            end else if (pullupSel_q) begin
               // Quasi-bidirectional: strong low, one-cycle strong high on 0->1, weak pull-up after
               pinOut_q[i]   <= latch_q[i];
               pinOeN_q[i]   <= ~(~latch_q[i] | (latch_q[i] & ~latchPrev_q[i]));
               pullupEn_q[i] <= latch_q[i];
            end else begin
               pinOut_q[i]   <= 1'b0;
               pinOeN_q[i]   <= latch_q[i];
               pullupEn_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule // port0_pad_ctrl

// file: verilog/power_ctrl.sv
// Power control register and idle / power-down sequencing
`timescale 1ns/1ps
module power_ctrl
   import core_sfr_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   sfr_write_if.unit          wr,
   input  wire logic          porEvent,
   input  wire logic          wakeEvent,
   output core_sfr_pkg::byte_t value,
   output logic               baudDouble_q,
   output logic               frameErrSel_q,
   output logic               cpuClockStop_q,
   output logic               allClockStop_q,
   output logic               enteredIdle,
   output logic               enteredDown,
   output logic               wokeUp
);
   power_state_e state_q;
   logic         por_q;
   logic         userB_q;
   logic         userA_q;
   logic         pconWrite;

   assign pconWrite = wr.we && wr.addr == ADDR_POWER_CTRL;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         baudDouble_q  <= RST_POWER_CTRL[PC_BAUD_DOUBLE];
         frameErrSel_q <= RST_POWER_CTRL[PC_FRAME_ERR_SEL];
         userB_q       <= RST_POWER_CTRL[PC_USER_FLAG_B];
         userA_q       <= RST_POWER_CTRL[PC_USER_FLAG_A];
      end else if (pconWrite) begin
         baudDouble_q  <= wr.wdata[PC_BAUD_DOUBLE];
         frameErrSel_q <= wr.wdata[PC_FRAME_ERR_SEL];
         userB_q       <= wr.wdata[PC_USER_FLAG_B];
         userA_q       <= wr.wdata[PC_USER_FLAG_A];
      end
   end

   // Flag is set by reset itself; a later power-on event wins over a clearing write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         por_q <= RST_POWER_CTRL[PC_POR_FLAG];
      end else if (porEvent) begin
         por_q <= 1'b1;
      end else if (pconWrite) begin
         por_q <= wr.wdata[PC_POR_FLAG];
      end
   end

   // Power-down takes priority when both request bits are written together
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= PWR_RUN;
      end else begin
         unique case (state_q)
            PWR_RUN: begin
               if (pconWrite && wr.wdata[PC_POWER_DOWN]) begin
                  state_q <= PWR_DOWN;
               end else if (pconWrite && wr.wdata[PC_CPU_HALT]) begin
                  state_q <= PWR_IDLE;
               end
            end
            PWR_IDLE, PWR_DOWN: begin
               if (wakeEvent) begin
                  state_q <= PWR_RUN;
               end
            end
            default: state_q <= PWR_RUN;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpuClockStop_q <= 1'b0;
         allClockStop_q <= 1'b0;
      end else begin
         cpuClockStop_q <= state_q != PWR_RUN;
         allClockStop_q <= state_q == PWR_DOWN;
      end
   end

   assign enteredIdle = state_q == PWR_RUN && pconWrite && !wr.wdata[PC_POWER_DOWN] && wr.wdata[PC_CPU_HALT];
   assign enteredDown = state_q == PWR_RUN && pconWrite && wr.wdata[PC_POWER_DOWN];
   assign wokeUp      = state_q != PWR_RUN && wakeEvent;

   // Reserved bit has no storage and reads 1
   assign value = {baudDouble_q, frameErrSel_q, 1'b1, por_q, userB_q, userA_q,
                   state_q == PWR_DOWN, state_q == PWR_IDLE};

endmodule // power_ctrl

// file: verilog/core_sfr_port_power_bank.sv
// Core register bank: port 0, stack top, data pointer, power control and event interrupt
`timescale 1ns/1ps
module core_sfr_port_power_bank
   import core_sfr_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire core_sfr_pkg::addr_t sfrAddr,
   input  wire core_sfr_pkg::byte_t sfrWdata,
   input  wire logic                sfrWrite,
   input  wire logic                sfrRead,
   output core_sfr_pkg::byte_t      sfrRdata,
   input  wire core_sfr_pkg::byte_t port0PinIn,
   output core_sfr_pkg::byte_t      port0PinOut,
   output core_sfr_pkg::byte_t      port0PinOeN,
   output core_sfr_pkg::byte_t      port0PullupEn,
   input  wire logic                extBusActive,
   input  wire logic                extBusDrive,
   input  wire core_sfr_pkg::byte_t extBusAddrData,
   input  wire logic                dptrIncrement,
   output core_sfr_pkg::byte_t      stackTopPointer,
   output logic [15:0]              dataPointer,
   input  wire logic                serialModeHiStored,
   input  wire logic                serialFrameErr,
   output logic                     serialModeHiOrFrameErr,
   output logic                     baudDouble,
   output logic                     frameErrorSelect,
   input  wire logic                porEvent,
   input  wire logic                wakeEvent,
   output logic                     cpuClockStop,
   output logic                     allClockStop,
   output logic                     irq
);

   // ****************************************************
   // Write channel to the sub-units
   // ****************************************************
   sfr_write_if wrBus ();

   assign wrBus.we    = sfrWrite;
   assign wrBus.addr  = sfrAddr;
   assign wrBus.wdata = sfrWdata;

   function automatic logic hit(input addr_t a, input addr_t target);
      return a == target;
   endfunction

   // ****************************************************
   // Port 0
   // ****************************************************
   byte_t port0Latch;
   logic  pullupSel;
   byte_t port0PinSync;

   port0_pad_ctrl u_port0 (
      .clk_sys        (clk_sys),
      .rst_n          (rst_n),
      .wr             (wrBus),
      .pinIn          (port0PinIn),
      .extBusActive   (extBusActive),
      .extBusDrive    (extBusDrive),
      .extBusAddrData (extBusAddrData),
      .latch_q        (port0Latch),
      .pullupSel_q    (pullupSel),
      .pinSync_q      (port0PinSync),
      .pinOut_q       (port0PinOut),
      .pinOeN_q       (port0PinOeN),
      .pullupEn_q     (port0PullupEn)
   );

   // ****************************************************
   // Power control
   // ****************************************************
   byte_t powerValue;
   logic  enteredIdle;
   logic  enteredDown;
   logic  wokeUp;

   power_ctrl u_power (
      .clk_sys        (clk_sys),
      .rst_n          (rst_n),
      .wr             (wrBus),
      .porEvent       (porEvent),
      .wakeEvent      (wakeEvent),
      .value          (powerValue),
      .baudDouble_q   (baudDouble),
      .frameErrSel_q  (frameErrorSelect),
      .cpuClockStop_q (cpuClockStop),
      .allClockStop_q (allClockStop),
      .enteredIdle    (enteredIdle),
      .enteredDown    (enteredDown),
      .wokeUp         (wokeUp)
   );

   // ****************************************************
   // Stack top pointer
   // ****************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stackTopPointer <= RST_STACK_TOP;
      end else if (sfrWrite && hit(sfrAddr, ADDR_STACK_TOP)) begin
         stackTopPointer <= sfrWdata;
      end
   end

   // ****************************************************
   // Data pointer
   // ****************************************************
   // A software write to a byte wins over the increment for that byte only
   logic [15:0] dptrNext;

   assign dptrNext = dataPointer + 16'h0001;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dataPointer[7:0] <= RST_DPTR_LOW;
      end else if (sfrWrite && hit(sfrAddr, ADDR_DPTR_LOW)) begin
         dataPointer[7:0] <= sfrWdata;
      end else if (dptrIncrement) begin
         dataPointer[7:0] <= dptrNext[7:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dataPointer[15:8] <= RST_DPTR_HIGH;
      end else if (sfrWrite && hit(sfrAddr, ADDR_DPTR_HIGH)) begin
         dataPointer[15:8] <= sfrWdata;
      end else if (dptrIncrement) begin
         dataPointer[15:8] <= dptrNext[15:8];
      end
   end

   // ****************************************************
   // Serial control bit 7 view
   // ****************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         serialModeHiOrFrameErr <= 1'b0;
      end else begin
         serialModeHiOrFrameErr <= frameErrorSelect ? serialFrameErr : serialModeHiStored;
      end
   end

   // ****************************************************
   // Event status, mask and interrupt
   // ****************************************************
   logic [EV_W-1:0] evStatus_q;
   logic [EV_W-1:0] evMask_q;
   logic [EV_W-1:0] evSet;
   logic [EV_W-1:0] evClear;
   logic [EV_W-1:0] evStatus_d;

   always_comb begin
      evSet                = '0;
      evSet[EV_IDLE_ENTRY] = enteredIdle;
      evSet[EV_DOWN_ENTRY] = enteredDown;
      evSet[EV_WAKE]       = wokeUp;
      evSet[EV_POR_SEEN]   = porEvent;
   end

   assign evClear    = (sfrWrite && hit(sfrAddr, ADDR_EVENT_STATUS)) ? sfrWdata[EV_W-1:0] : '0;
   // Set beats clear so an event landing on the clearing write is kept
   assign evStatus_d = (evStatus_q & ~evClear) | evSet;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         evStatus_q <= '0;
      end else begin
         evStatus_q <= evStatus_d;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         evMask_q <= RST_EVENT_MASK;
      end else if (sfrWrite && hit(sfrAddr, ADDR_EVENT_MASK)) begin
         evMask_q <= sfrWdata[EV_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evStatus_d & evMask_q);
      end
   end

   // ****************************************************
   // Read path
   // ****************************************************
   // Port 0 reads return the synchronised pin levels, so a pin held low
   // by the outside shows even when the latch holds a one.
   byte_t readMux;

   always_comb begin
      unique case (sfrAddr)
         ADDR_PORT0_LATCH:  readMux = port0PinSync;
         ADDR_STACK_TOP:    readMux = stackTopPointer;
         ADDR_DPTR_LOW:     readMux = dataPointer[7:0];
         ADDR_DPTR_HIGH:    readMux = dataPointer[15:8];
         ADDR_PULLUP_OPT:   readMux = {7'h7f, pullupSel};
         ADDR_POWER_CTRL:   readMux = powerValue;
         ADDR_EVENT_STATUS: readMux = {4'hf, evStatus_q};
         ADDR_EVENT_MASK:   readMux = {4'hf, evMask_q};
         default:           readMux = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sfrRdata <= 8'h00;
      end else if (sfrRead) begin
         sfrRdata <= readMux;
      end else begin
         sfrRdata <= 8'h00;
      end
   end

endmodule // core_sfr_port_power_bank

// file: dv/core_sfr_port_power_bank_monitor.sv
// Checker for the core register bank: register bus, pads, power modes and serial view
`timescale 1ns/1ps
module core_sfr_port_power_bank_monitor
   import core_sfr_pkg::*;
(
   input wire logic                clk_sys,
   input wire logic                rst_n,
   input wire core_sfr_pkg::addr_t sfrAddr,
   input wire core_sfr_pkg::byte_t sfrWdata,
   input wire logic                sfrWrite,
   input wire logic                sfrRead,
   input wire core_sfr_pkg::byte_t sfrRdata,
   input wire core_sfr_pkg::byte_t port0PinOut,
   input wire core_sfr_pkg::byte_t port0PinOeN,
   input wire core_sfr_pkg::byte_t port0PullupEn,
   input wire logic                extBusActive,
   input wire logic                extBusDrive,
   input wire core_sfr_pkg::byte_t extBusAddrData,
   input wire core_sfr_pkg::byte_t stackTopPointer,
   input wire logic [15:0]         dataPointer,
   input wire logic                serialModeHiStored,
   input wire logic                serialFrameErr,
   input wire logic                serialModeHiOrFrameErr,
   input wire logic                baudDouble,
   input wire logic                frameErrorSelect,
   input wire logic                wakeEvent,
   input wire logic                cpuClockStop,
   input wire logic                allClockStop,
   input wire logic                irq
);
   import core_sfr_pkg::*;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic pcWr;
   assign pcWr = sfrWrite && sfrAddr == ADDR_POWER_CTRL;

   function automatic logic mapped(input addr_t a);
      return a inside {ADDR_PORT0_LATCH, ADDR_STACK_TOP, ADDR_DPTR_LOW, ADDR_DPTR_HIGH,
                       ADDR_PULLUP_OPT, ADDR_POWER_CTRL, ADDR_EVENT_STATUS, ADDR_EVENT_MASK};
   endfunction

   AST_RDATA_QUIET: assert property (!$past(sfrRead) |-> sfrRdata == 8'h00)
      else $error("read data not zero outside answer");
   AST_UNMAPPED_HIGH: assert property ($past(sfrRead) && !mapped($past(sfrAddr)) |-> sfrRdata == 8'hff)
      else $error("unmapped read not all ones");
   AST_STACK_READBACK: assert property ($past(sfrRead) && $past(sfrAddr) == ADDR_STACK_TOP |->
      sfrRdata == $past(stackTopPointer)) else $error("stack readback wrong");
   AST_STACK_WRITE: assert property (sfrWrite && sfrAddr == ADDR_STACK_TOP |=>
      stackTopPointer == $past(sfrWdata)) else $error("stack write lost");
   AST_DPTR_LOW: assert property (sfrWrite && sfrAddr == ADDR_DPTR_LOW |=>
      dataPointer[7:0] == $past(sfrWdata)) else $error("pointer low byte wrong");
   AST_POWER_CONTROL_MODES: assert property (pcWr |=> {baudDouble, frameErrorSelect} == $past(sfrWdata[7:6]))
      else $error("baud or frame select not taken");
   AST_SERIAL_VIEW: assert property ($past(rst_n) && frameErrorSelect && $past(frameErrorSelect)
      && $past(frameErrorSelect, 2) |-> serialModeHiOrFrameErr == $past(serialFrameErr))
      else $error("frame error view wrong");
   AST_EXT_BUS: assert property ($past(extBusActive) |-> port0PinOut == $past(extBusAddrData)
      && port0PinOeN == ~{8{$past(extBusDrive)}} && port0PullupEn == 8'h00) else $error("ext bus pads wrong");
   AST_NO_STRONG_HIGH: assert property ($past(rst_n) && !$past(extBusActive) |->
      (port0PinOut & ~port0PullupEn) == 8'h00) else $error("high driven without pull-up");
   AST_IDLE_ENTRY: assert property (pcWr && sfrWdata[1:0] == 2'b01 && !cpuClockStop && !wakeEvent
      ##1 !wakeEvent |-> ##1 cpuClockStop && !allClockStop) else $error("idle not entered");
   AST_DOWN_ENTRY: assert property (pcWr && sfrWdata[1] && !cpuClockStop && !wakeEvent
      ##1 !wakeEvent |-> ##1 cpuClockStop && allClockStop) else $error("power-down not entered");

   COV_IDLE: cover property (cpuClockStop && !allClockStop);
   COV_DOWN: cover property (allClockStop);
   COV_IRQ: cover property (irq);
   COV_EXT: cover property (extBusActive ##1 extBusActive);

endmodule // core_sfr_port_power_bank_monitor

bind core_sfr_port_power_bank core_sfr_port_power_bank_monitor core_sfr_port_power_bank_monitor_inst (
   .clk_sys, .rst_n, .sfrAddr, .sfrWdata, .sfrWrite, .sfrRead, .sfrRdata, .port0PinOut, .port0PinOeN,
   .port0PullupEn, .extBusActive, .extBusDrive, .extBusAddrData, .stackTopPointer, .dataPointer,
   .serialModeHiStored, .serialFrameErr, .serialModeHiOrFrameErr, .baudDouble, .frameErrorSelect,
   .wakeEvent, .cpuClockStop, .allClockStop, .irq);

// file: dv/tb_top.sv
// Self-checking bench for the core register bank
`timescale 1ns/1ps
module tb_top;
   import core_sfr_pkg::*;

   logic        clk_sys, rst_n, sfrWrite, sfrRead, extBusActive, extBusDrive, dptrIncrement;
   logic        serialModeHiStored, serialFrameErr, porEvent, wakeEvent, serialModeHiOrFrameErr;
   logic        baudDouble, frameErrorSelect, cpuClockStop, allClockStop, irq;
   addr_t       sfrAddr;
   byte_t       sfrWdata, port0PinIn, extBusAddrData, sfrRdata, port0PinOut, port0PinOeN;
   byte_t       port0PullupEn, stackTopPointer;
   logic [15:0] dataPointer;
   int          numErrors = 0, samplesChecked = 0, cycles = 0;
   // Reset view: address, expected read
   logic [15:0] rstRows [8] = '{16'h8107, 16'h8200, 16'h8300, 16'h86ff, 16'h8730, 16'hfaf0, 16'hf9f0, 16'h805a};
   // Ordinary cases: address, write data, expected read back
   logic [23:0] rows [13] = '{24'h815a5a, 24'h81a5a5, 24'h823c3c, 24'h83c3c3, 24'h8600fe, 24'h8601ff,
      24'h870c2c, 24'h87c4e4, 24'hfa05f5, 24'h8477ff, 24'h8500ff, 24'h8812ff, 24'hff34ff};

   core_sfr_port_power_bank core_sfr_port_power_bank_inst (
      .clk_sys, .rst_n, .sfrAddr, .sfrWdata, .sfrWrite, .sfrRead, .sfrRdata, .port0PinIn, .port0PinOut,
      .port0PinOeN, .port0PullupEn, .extBusActive, .extBusDrive, .extBusAddrData, .dptrIncrement,
      .stackTopPointer, .dataPointer, .serialModeHiStored, .serialFrameErr, .serialModeHiOrFrameErr,
      .baudDouble, .frameErrorSelect, .porEvent, .wakeEvent, .cpuClockStop, .allClockStop, .irq);

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         numErrors++;
         summarize();
      end
   end

   // ****************************************************
   // Bus and compare tasks
   // ****************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         numErrors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input addr_t a, input byte_t d);
      @(posedge clk_sys);
      sfrWrite <= 1'b1;
      sfrAddr  <= a;
      sfrWdata <= d;
      @(posedge clk_sys);
      sfrWrite <= 1'b0;
   endtask

   task automatic rc(input addr_t a, input byte_t exp);
      @(posedge clk_sys);
      sfrRead <= 1'b1;
      sfrAddr <= a;
      @(posedge clk_sys);
      sfrRead <= 1'b0;
      #1;
      chk(16'(sfrRdata), 16'(exp));
   endtask

   task automatic wake();
      @(posedge clk_sys);
      wakeEvent <= 1'b1;
      @(posedge clk_sys);
      wakeEvent <= 1'b0;
      w(3);
   endtask

   task automatic summarize();
      $display("checked %0d mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      {rst_n, sfrWrite, sfrRead, extBusActive, extBusDrive, dptrIncrement} = '0;
      {serialModeHiStored, serialFrameErr, porEvent, wakeEvent} = '0;
      {sfrAddr, sfrWdata, extBusAddrData} = '0;
      port0PinIn = 8'h5a;
      repeat (10) @(posedge clk_sys);
      chk(16'(port0PinOut), 16'h00ff);
      rst_n <= 1'b1;
      w(2);
      chk(16'({port0PinOeN, port0PullupEn}), 16'hffff);
      for (int i = 0; i < 8; i++) rc(rstRows[i][15:8], rstRows[i][7:0]);
      for (int i = 0; i < 13; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rc(rows[i][23:16], rows[i][7:0]);
      end
      chk(16'({stackTopPointer, baudDouble, frameErrorSelect}), 16'h0297);
      chk(dataPointer, 16'hc33c);
      @(posedge clk_sys) dptrIncrement <= 1'b1;
      @(posedge clk_sys) dptrIncrement <= 1'b0;
      w(1);
      chk(dataPointer, 16'hc33d);
      @(posedge clk_sys) serialFrameErr <= 1'b1;
      w(4);
      chk(16'(serialModeHiOrFrameErr), 16'h1);
      wr(ADDR_POWER_CTRL, 8'h00);
      w(4);
      chk(16'(serialModeHiOrFrameErr), 16'h0);
      @(posedge clk_sys) serialModeHiStored <= 1'b1;
      w(3);
      chk(16'({baudDouble, serialModeHiOrFrameErr}), 16'h1);
      wr(ADDR_PULLUP_OPT, 8'h00);
      wr(ADDR_PORT0_LATCH, 8'h0f);
      w(3);
      chk({port0PinOut, port0PinOeN}, 16'h000f);
      chk(16'(port0PullupEn), 16'h0000);
      wr(ADDR_PULLUP_OPT, 8'h01);
      w(3);
      chk(16'({port0PinOeN, port0PullupEn}), 16'h0f0f);
      @(posedge clk_sys);
      extBusActive   <= 1'b1;
      extBusDrive    <= 1'b1;
      extBusAddrData <= 8'ha5;
      w(2);
      chk({port0PinOut, port0PinOeN}, 16'ha500);
      chk(16'(port0PullupEn), 16'h0000);
      @(posedge clk_sys) extBusDrive <= 1'b0;
      w(2);
      chk(16'(port0PinOeN), 16'h00ff);
      @(posedge clk_sys) extBusActive <= 1'b0;
      wr(ADDR_EVENT_MASK, 8'h0f);
      wr(ADDR_POWER_CTRL, 8'h01);
      w(3);
      chk(16'({cpuClockStop, allClockStop, irq}), 16'h5);
      rc(ADDR_EVENT_STATUS, 8'hf1);
      rc(ADDR_POWER_CTRL, 8'h21);
      wake();
      chk(16'(cpuClockStop), 16'h0);
      rc(ADDR_POWER_CTRL, 8'h20);
      rc(ADDR_EVENT_STATUS, 8'hf5);
      wr(ADDR_EVENT_STATUS, 8'h0f);
      w(2);
      chk(16'(irq), 16'h0);
      // Both request bits at once: power-down must win
      wr(ADDR_POWER_CTRL, 8'h03);
      w(3);
      chk(16'({allClockStop, cpuClockStop}), 16'h3);
      wake();
      chk(16'({allClockStop, cpuClockStop}), 16'h0);
      rc(ADDR_EVENT_STATUS, 8'hf6);
      wr(ADDR_EVENT_STATUS, 8'h0f);
      wr(ADDR_EVENT_MASK, 8'h00);
      @(posedge clk_sys) porEvent <= 1'b1;
      @(posedge clk_sys) porEvent <= 1'b0;
      w(2);
      chk(16'(irq), 16'h0);
      rc(ADDR_POWER_CTRL, 8'h30);
      wr(ADDR_EVENT_MASK, 8'h08);
      w(2);
      chk(16'(irq), 16'h1);
      wr(ADDR_EVENT_STATUS, 8'h08);
      w(2);
      chk(16'(irq), 16'h0);
      rc(ADDR_POWER_CTRL, 8'h30);
      wr(ADDR_POWER_CTRL, 8'h00);
      rc(ADDR_POWER_CTRL, 8'h20);
      @(posedge clk_sys) rst_n <= 1'b0;
      w(3);
      chk({stackTopPointer, 8'h00}, 16'h0700);
      chk(dataPointer, 16'h0000);
      @(posedge clk_sys) rst_n <= 1'b1;
      rc(ADDR_POWER_CTRL, 8'h30);
      rc(ADDR_STACK_TOP, 8'h07);
      summarize();
   end

endmodule // tb_top
